// File: rtl/icnvm_top.sv
// I2C configuration port with register map, shadow memory and store.
// Assumes bus pins synchronous to clk and an external open-drain wire.
`timescale 1ns/1ns
module icnvm_top (
   // System
   input wire logic clk,
   input wire logic reset,
   // I2C bus
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Three-level straps, coded 0..2
   input wire logic [1:0] address_strap_pin,
   input wire logic [1:0] page_strap_hi,
   input wire logic [1:0] page_strap_lo,
   // Status
   output logic nvm_busy
);

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------
   logic [1:0] raw;
   logic [1:0] filt_ff;
   logic [2:0] gcnt_ff [2];
   icnvm_pkg::icnvm_bus_t bus;
   icnvm_pkg::icnvm_bus_t bus_d_ff;
   logic scl_rise, scl_fall, start_det, stop_det;
   icnvm_pkg::icnvm_state_t state_ff;
   icnvm_pkg::icnvm_phase_t phase_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic rd_ff, ack_ok_ff;
   logic [1:0] addr_low_ff;
   logic [3:0] boot_page_ff;
   logic [3:0] pin_page;
   logic byte_done, addr_ok, wr_stb, load_tx;
   logic [7:0] idx_ff;
   logic [7:0] rd_data;
   logic [7:0] regs_ff [icnvm_pkg::REG_BYTES];
   logic [7:0] sram_ff [icnvm_pkg::MEM_BYTES];
   logic [7:0] nvm_ff [icnvm_pkg::MEM_BYTES];
   logic [8:0] ptr_ff;
   logic mem_act_ff;
   logic [7:0] count_ff, key_ff;
   logic [3:0] psel_ff;
   icnvm_pkg::icnvm_eng_t eng_ff;
   logic eng_last, mem_rd, mem_wr, go_commit, go_prog;

   function automatic logic [8:0] page_base(input logic [3:0] page);
      page_base = icnvm_pkg::BASE_BYTES + 9'(page) * icnvm_pkg::PAGE_BYTES;
   endfunction

   // ---------------------------------------------------------------
   // Input glitch filter
   // ---------------------------------------------------------------
   // A level must hold for the full window before it is believed.
   assign raw = {scl_in, sda_in};

   always_ff @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         if (reset) begin
            filt_ff[i] <= 1'b1;
            gcnt_ff[i] <= 3'h0;
         end else if (raw[i] == filt_ff[i]) begin
            gcnt_ff[i] <= 3'h0;
         end else if (gcnt_ff[i] == icnvm_pkg::GLITCH_LAST) begin
            filt_ff[i] <= raw[i];
            gcnt_ff[i] <= 3'h0;
         end else begin
            gcnt_ff[i] <= gcnt_ff[i] + 3'h1;
         end
      end
   end

   assign bus = icnvm_pkg::icnvm_bus_t'(filt_ff);

   always_ff @(posedge clk) begin
      if (reset) begin
         bus_d_ff <= icnvm_pkg::icnvm_bus_t'(2'h3);
      end else begin
         bus_d_ff <= bus;
      end
   end

   assign scl_rise = bus.scl & ~bus_d_ff.scl;
   assign scl_fall = ~bus.scl & bus_d_ff.scl;
   assign start_det = bus.scl & bus_d_ff.scl & bus_d_ff.sda & ~bus.sda;
   assign stop_det = bus.scl & bus_d_ff.scl & ~bus_d_ff.sda & bus.sda;

   // ---------------------------------------------------------------
   // Straps, caught while reset is held
   // ---------------------------------------------------------------
   assign pin_page = ({2'h0, page_strap_hi} << 1) + {2'h0, page_strap_hi} + {2'h0, page_strap_lo};

   always_ff @(posedge clk) begin
      if (reset) begin
         addr_low_ff <= address_strap_pin;
         boot_page_ff <= (pin_page < icnvm_pkg::NUM_PAGES) ? pin_page : 4'h0;
      end
   end

   // ---------------------------------------------------------------
   // Protocol engine
   // ---------------------------------------------------------------
   assign byte_done = (state_ff == icnvm_pkg::ST_RX) && scl_fall
                      && (bit_cnt_ff == icnvm_pkg::BYTE_BITS);
   // Address refused while the boot copy still runs
   assign addr_ok = (shift_ff[7:1] == {icnvm_pkg::SLAVE_ADDR_HI, addr_low_ff})
                    && (eng_ff.mode != icnvm_pkg::ENG_INIT);
   assign wr_stb = byte_done && (phase_ff == icnvm_pkg::PH_DATA);
   assign load_tx = scl_fall && (((state_ff == icnvm_pkg::ST_RACK) && rd_ff)
                    || ((state_ff == icnvm_pkg::ST_TACK) && ack_ok_ff));

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= icnvm_pkg::ST_IDLE;
         phase_ff <= icnvm_pkg::PH_ADDR;
         bit_cnt_ff <= 4'h0;
         shift_ff <= icnvm_pkg::RESET_BYTE;
         tx_ff <= icnvm_pkg::RESET_BYTE;
         rd_ff <= 1'b0;
         ack_ok_ff <= 1'b0;
      end else if (stop_det) begin
         state_ff <= icnvm_pkg::ST_IDLE;
      end else if (start_det) begin
         state_ff <= icnvm_pkg::ST_RX;
         phase_ff <= icnvm_pkg::PH_ADDR;
         bit_cnt_ff <= 4'h0;
      end else begin
         unique case (state_ff)
            icnvm_pkg::ST_IDLE: begin
               bit_cnt_ff <= 4'h0;
            end
            icnvm_pkg::ST_RX: begin
               if (scl_rise) begin
                  shift_ff <= {shift_ff[6:0], bus.sda};
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end else if (byte_done) begin
                  bit_cnt_ff <= 4'h0;
                  if (phase_ff == icnvm_pkg::PH_ADDR && !addr_ok) begin
                     state_ff <= icnvm_pkg::ST_IDLE;
                  end else begin
                     state_ff <= icnvm_pkg::ST_RACK;
                     if (phase_ff == icnvm_pkg::PH_ADDR) begin
                        rd_ff <= shift_ff[0];
                        phase_ff <= icnvm_pkg::PH_INDEX;
                     end else begin
                        phase_ff <= icnvm_pkg::PH_DATA;
                     end
                  end
               end
            end
            icnvm_pkg::ST_RACK: begin
               if (scl_fall) begin
                  state_ff <= rd_ff ? icnvm_pkg::ST_TX : icnvm_pkg::ST_RX;
                  tx_ff <= rd_data;
               end
            end
            icnvm_pkg::ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_ff <= bit_cnt_ff + 4'h1;
               end else if (scl_fall && bit_cnt_ff == icnvm_pkg::BYTE_BITS) begin
                  state_ff <= icnvm_pkg::ST_TACK;
                  bit_cnt_ff <= 4'h0;
               end else if (scl_fall) begin
                  tx_ff <= {tx_ff[6:0], 1'b0};
               end
            end
            icnvm_pkg::ST_TACK: begin
               if (scl_rise) begin
                  ack_ok_ff <= ~bus.sda;
               end else if (scl_fall && ack_ok_ff) begin
                  state_ff <= icnvm_pkg::ST_TX;
                  tx_ff <= rd_data;
               end else if (scl_fall) begin
                  state_ff <= icnvm_pkg::ST_IDLE;
               end
            end
            default: begin
               state_ff <= icnvm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Data line drive
   // ---------------------------------------------------------------
   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe = (state_ff == icnvm_pkg::ST_RACK)
                   || ((state_ff == icnvm_pkg::ST_TX) && !tx_ff[7]);

   // ---------------------------------------------------------------
   // Register index
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         idx_ff <= icnvm_pkg::RESET_BYTE;
      end else if (byte_done && phase_ff == icnvm_pkg::PH_INDEX) begin
         idx_ff <= shift_ff;
      end else if (wr_stb || load_tx) begin
         idx_ff <= idx_ff + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Read mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_data = regs_ff[idx_ff];
      unique case (idx_ff)
         icnvm_pkg::OFS_PROG_COUNT: rd_data = count_ff;
         icnvm_pkg::OFS_NVM_CTRL: begin
            rd_data = 8'h00;
            rd_data[icnvm_pkg::CTL_BUSY_BIT] = nvm_busy;
         end
         icnvm_pkg::OFS_PTR_HIGH: rd_data = {7'h00, ptr_ff[8]};
         icnvm_pkg::OFS_PTR_LOW: rd_data = ptr_ff[7:0];
         icnvm_pkg::OFS_MEM_DATA: rd_data = mem_act_ff ? sram_ff[ptr_ff] : 8'h00;
         icnvm_pkg::OFS_UNLOCK: rd_data = key_ff;
         icnvm_pkg::OFS_PAGE_SEL: rd_data = {4'h0, psel_ff};
         default: begin
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   assign go_commit = wr_stb && idx_ff == icnvm_pkg::OFS_NVM_CTRL
                      && shift_ff[icnvm_pkg::CTL_COMMIT_BIT]
                      && psel_ff <= icnvm_pkg::PAGE_MAX
                      && eng_ff.mode == icnvm_pkg::ENG_IDLE;
   assign go_prog = wr_stb && idx_ff == icnvm_pkg::OFS_NVM_CTRL
                    && shift_ff[icnvm_pkg::CTL_PROG_BIT]
                    && key_ff == icnvm_pkg::UNLOCK_CODE
                    && eng_ff.mode == icnvm_pkg::ENG_IDLE;

   always_ff @(posedge clk) begin
      if (reset) begin
         key_ff <= icnvm_pkg::RESET_BYTE;
         psel_ff <= 4'h0;
      end else if (wr_stb && idx_ff == icnvm_pkg::OFS_UNLOCK) begin
         key_ff <= shift_ff;
      end else if (wr_stb && idx_ff == icnvm_pkg::OFS_PAGE_SEL) begin
         psel_ff <= shift_ff[3:0];
      end
   end

   // ---------------------------------------------------------------
   // Shadow memory pointer
   // ---------------------------------------------------------------
   assign mem_wr = wr_stb && idx_ff == icnvm_pkg::OFS_MEM_DATA && mem_act_ff && !nvm_busy;
   assign mem_rd = load_tx && idx_ff == icnvm_pkg::OFS_MEM_DATA && mem_act_ff;
   // A stop ends indirect access; a repeated start keeps the pointer live

   always_ff @(posedge clk) begin
      if (reset) begin
         ptr_ff <= 9'h000;
         mem_act_ff <= 1'b0;
      end else if (stop_det) begin
         mem_act_ff <= 1'b0;
      end else if (wr_stb && idx_ff == icnvm_pkg::OFS_PTR_HIGH) begin
         ptr_ff[8] <= shift_ff[0];
      end else if (wr_stb && idx_ff == icnvm_pkg::OFS_PTR_LOW) begin
         ptr_ff[7:0] <= shift_ff;
         mem_act_ff <= 1'b1;
      end else if (mem_wr || mem_rd) begin
         ptr_ff <= ptr_ff + 9'h001;
      end
   end

   // ---------------------------------------------------------------
   // Copy engine: boot load, page commit, store programming
   // ---------------------------------------------------------------
   // One byte per clock; the bus is far slower, so no handshake needed.
   assign eng_last = (eng_ff.mode == icnvm_pkg::ENG_PROG) ? (eng_ff.cnt == icnvm_pkg::MEM_LAST)
                     : (eng_ff.cnt == icnvm_pkg::PAGE_LAST);
   // Only store programming shows busy; a commit is short enough to need none
   assign nvm_busy = (eng_ff.mode == icnvm_pkg::ENG_PROG);

   always_ff @(posedge clk) begin
      if (reset) begin
         eng_ff <= '{mode: icnvm_pkg::ENG_INIT, cnt: 9'h000, page: 4'h0};
      end else if (eng_ff.mode == icnvm_pkg::ENG_IDLE) begin
         if (go_commit) begin
            eng_ff <= '{mode: icnvm_pkg::ENG_COMMIT, cnt: 9'h000, page: psel_ff};
         end else if (go_prog) begin
            eng_ff <= '{mode: icnvm_pkg::ENG_PROG, cnt: 9'h000, page: 4'h0};
         end
      end else if (eng_last) begin
         eng_ff.mode <= icnvm_pkg::ENG_IDLE;
      end else begin
         eng_ff.cnt <= eng_ff.cnt + 9'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         count_ff <= icnvm_pkg::RESET_BYTE;
      end else if (nvm_busy && eng_last) begin
         count_ff <= count_ff + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Storage arrays
   // ---------------------------------------------------------------
   // Store is non-volatile: never cleared by reset
   always_ff @(posedge clk) begin
      if (nvm_busy) begin
         nvm_ff[eng_ff.cnt] <= sram_ff[eng_ff.cnt];
      end
   end

   always_ff @(posedge clk) begin
      if (eng_ff.mode == icnvm_pkg::ENG_COMMIT) begin
         sram_ff[page_base(eng_ff.page) + eng_ff.cnt] <= regs_ff[eng_ff.cnt[7:0]];
      end else if (mem_wr) begin
         sram_ff[ptr_ff] <= shift_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < icnvm_pkg::REG_BYTES; i++) begin
            regs_ff[i] <= icnvm_pkg::RESET_BYTE;
         end
      end else if (eng_ff.mode == icnvm_pkg::ENG_INIT) begin
         regs_ff[eng_ff.cnt[7:0]] <= nvm_ff[page_base(boot_page_ff) + eng_ff.cnt];
      end else if (wr_stb) begin
         regs_ff[idx_ff] <= shift_ff;
      end
   end

endmodule // icnvm_top

// File: rtl/icnvm_pkg.sv
// Constants, types and register map of the configuration port block.
// Assumes a 100 MHz core clock and a synchronous, active-high reset.
// ---------------------------------------------------------------
// Summary of operation
// - Works at 100 kHz and 400 kHz.
// - Ignore SDA/SCL pulses shorter than 50 ns.
// - Address 10101 plus two strap bits.
// - Start and stop only while SCL high.
// - Bytes MSB first, ack on ninth clock.
// - Acknowledge only a matching address, else idle.
// - Read ends on master not-acknowledge; release SDA.
// - Block write: index then data, index increments.
// - Block read after repeated start, index increments.
// - Keep sending while master acknowledges.
// - Commit trigger copies registers to selected page.
// - Pointer registers address shadow memory writes.
// - Shadow data reads walk pointer, end at stop.
// - Six stored pages; boot page from pins.
// - Busy flag high while programming; access blocked (code blocks only shadow memory writes and new triggers).
// - Program trigger copies image, counter increments.
// - Read-only and reserved bits ignore writes.
// ---------------------------------------------------------------
package icnvm_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int GLITCH_NS = 50;
   localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] GLITCH_LAST = 3'(GLITCH_CYC - 1);

   // ---------------------------------------------------------------
   // Bus address and register map
   // ---------------------------------------------------------------
   localparam logic [4:0] SLAVE_ADDR_HI = 5'h15;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [7:0] OFS_PROG_COUNT = 8'h88;
   localparam logic [7:0] OFS_NVM_CTRL = 8'h89;
   localparam logic [7:0] OFS_PTR_HIGH = 8'h8B;
   localparam logic [7:0] OFS_PTR_LOW = 8'h8C;
   localparam logic [7:0] OFS_MEM_DATA = 8'h8E;
   localparam logic [7:0] OFS_UNLOCK = 8'h90;
   localparam logic [7:0] OFS_PAGE_SEL = 8'h91;
   localparam int CTL_PROG_BIT = 0;
   localparam int CTL_BUSY_BIT = 2;
   localparam int CTL_COMMIT_BIT = 6;
   localparam logic [7:0] UNLOCK_CODE = 8'hEA;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // ---------------------------------------------------------------
   // Memory layout
   // ---------------------------------------------------------------
   localparam int MEM_BYTES = 512;
   localparam int REG_BYTES = 256;
   localparam logic [8:0] BASE_BYTES = 9'h080;
   localparam logic [8:0] PAGE_BYTES = 9'h040;
   localparam logic [8:0] PAGE_LAST = 9'h03F;
   localparam logic [8:0] MEM_LAST = 9'h1FF;
   localparam logic [3:0] NUM_PAGES = 4'h6;
   localparam logic [3:0] PAGE_MAX = 4'h5;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_RX = 3'h1,
      ST_RACK = 3'h3,
      ST_TX = 3'h2,
      ST_TACK = 3'h6
   } icnvm_state_t;

   typedef enum logic [1:0] {
      PH_ADDR = 2'h0,
      PH_INDEX = 2'h1,
      PH_DATA = 2'h2
   } icnvm_phase_t;

   typedef enum logic [1:0] {
      ENG_IDLE = 2'h0,
      ENG_INIT = 2'h1,
      ENG_COMMIT = 2'h3,
      ENG_PROG = 2'h2
   } icnvm_eng_mode_t;

   typedef struct packed {
      icnvm_eng_mode_t mode;
      logic [8:0] cnt;
      logic [3:0] page;
   } icnvm_eng_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } icnvm_bus_t;

endpackage

// File: bench/icnvm_asserts.sv
// Pin-level checker for the configuration port.
// Assumes one clock domain and a bind onto icnvm_top.
`timescale 1ns/1ns
module icnvm_asserts (
   // System
   input wire logic clk,
   input wire logic reset,
   // Bus
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Status
   input wire logic nvm_busy
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   // ---------------------------------------------------------------
   // Helper count
   // ---------------------------------------------------------------
   // Holds the busy length at the falling edge, cleared while idle
   logic [9:0] busy_cnt_ff;
   always_ff @(posedge clk) begin
      if (reset || !nvm_busy) begin
         busy_cnt_ff <= 10'h000;
      end else begin
         busy_cnt_ff <= busy_cnt_ff + 10'h001;
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   sequence s_start;
      scl_in && $fell(sda_in);
   endsequence
   sequence s_stop;
      scl_in && $rose(sda_in);
   endsequence
   property p_oe_scl_high;
      scl_in |-> $stable(sda_oe);
   endproperty
   property p_oe_settle;
      $changed(sda_oe) |-> !scl_in && !$past(scl_in, 5);
   endproperty
   property p_od_low;
      sda_oe |-> !sda_out && !sda_in;
   endproperty
   property p_idle_start;
      s_start |=> !sda_oe [*8];
   endproperty
   property p_idle_stop;
      s_stop |=> !sda_oe [*8];
   endproperty
   property p_busy_hold;
      $rose(nvm_busy) |=> nvm_busy [*8];
   endproperty
   property p_busy_len;
      $fell(nvm_busy) |-> busy_cnt_ff >= 10'h200 && busy_cnt_ff <= 10'h204;
   endproperty
   property p_busy_src;
      $rose(nvm_busy) |-> !scl_in;
   endproperty
   a_oe_scl_high: assert property (p_oe_scl_high)
      else $error("data drive moved while clock high");
   a_oe_settle: assert property (p_oe_settle)
      else $error("data drive moved too soon after clock fall");
   a_od_low: assert property (p_od_low)
      else $error("driven data not low");
   a_idle_start: assert property (p_idle_start)
      else $error("data driven right after start");
   a_idle_stop: assert property (p_idle_stop)
      else $error("data driven right after stop");
   a_busy_hold: assert property (p_busy_hold)
      else $error("busy dropped early");
   a_busy_len: assert property (p_busy_len)
      else $error("programming length wrong");
   a_busy_src: assert property (p_busy_src)
      else $error("programming began outside a bus write");
endmodule // icnvm_asserts

bind icnvm_top icnvm_asserts i_chk (.clk(clk), .reset(reset), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .nvm_busy(nvm_busy));

// File: bench/icnvm_host.sv
// Bus master model: drives clock and data, reads the resolved wire.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ns
module icnvm_host #(parameter int QTR = 40) (
   // System
   input wire logic clk,
   // Bus
   output logic scl,
   output logic sda,
   input wire logic sda_wire
);
   // Released wires read high
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   // ---------------------------------------------------------------
   // Bus steps; a short quarter period keeps the run brief, above fast mode
   // ---------------------------------------------------------------
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic xfer(input logic b, output logic v);
      sda <= b;
      w(QTR);
      scl <= 1'b1;
      w(QTR);
      v = sda_wire;
      w(QTR);
      scl <= 1'b0;
      w(QTR);
   endtask
   task automatic start();
      sda <= 1'b1;
      w(QTR);
      scl <= 1'b1;
      w(QTR);
      sda <= 1'b0;
      w(QTR);
      scl <= 1'b0;
      w(QTR);
   endtask
   task automatic stop();
      sda <= 1'b0;
      w(QTR);
      scl <= 1'b1;
      w(QTR);
      sda <= 1'b1;
      w(2 * QTR);
   endtask
   // Short pulse on the clock line, meant to be filtered out
   task automatic spike(input int n);
      scl <= ~scl;
      w(n);
      scl <= ~scl;
      w(n);
   endtask
   // Ninth bit: rel high leaves the wire free, for ack or for not-ack
   task automatic xb(input logic [7:0] d, input logic rel, output logic [7:0] q,
                     output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         xfer(d[i], q[i]);
      end
      xfer(rel, a);
      ack = !a;
   endtask
endmodule // icnvm_host

// File: bench/tb.sv
// Self-checking bench for the configuration port.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic scl_m;
   logic sda_m;
   logic sda_out;
   logic sda_oe;
   logic nvm_busy;
   logic sda_wire;
   logic [7:0] q;
   logic a;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;

   always #5 clk = ~clk;
   // Open-drain wire with pull-up
   assign sda_wire = sda_m & ~(sda_oe & ~sda_out);

   icnvm_top i_icnvm_top (.clk(clk), .reset(reset), .scl_in(scl_m), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_pin(2'h2),
      .page_strap_hi(2'h1), .page_strap_lo(2'h1), .nvm_busy(nvm_busy));
   icnvm_host i_host (.clk(clk), .scl(scl_m), .sda(sda_m), .sda_wire(sda_wire));

   // ---------------------------------------------------------------
   // Access tasks
   // ---------------------------------------------------------------
   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic tx(input logic [7:0] d, input logic exp_ack);
      i_host.xb(d, 1'b1, q, a);
      `CHK("ack", exp_ack, a)
   endtask
   task automatic rx(input logic [7:0] e, input logic last);
      i_host.xb(8'hFF, last, q, a);
      `CHK("read byte", e, q)
   endtask
   task automatic adr(input logic rd);
      i_host.start();
      tx({icnvm_pkg::SLAVE_ADDR_HI, 2'h2, rd}, 1'b1);
   endtask

   // Hang guard, a little above the expected run
   always @(posedge clk) begin
      cyc++;
      if (cyc > 95000) begin
         bad_count++;
         complete_run();
      end
   end

   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      // Boot copy runs 64 cycles first
      repeat (80) @(posedge clk);
      i_host.start();
      tx(8'hA0, 1'b0);
      i_host.stop();
      adr(1'b0);
      tx(8'hFF, 1'b1);
      tx(8'h3C, 1'b1);
      i_host.spike(icnvm_pkg::GLITCH_CYC - 1);
      tx(8'hC3, 1'b1);
      i_host.stop();
      adr(1'b0);
      tx(8'hFF, 1'b1);
      adr(1'b1);
      rx(8'h3C, 1'b0);
      rx(8'hC3, 1'b1);
      i_host.stop();
      adr(1'b0);
      tx(icnvm_pkg::OFS_PROG_COUNT, 1'b1);
      tx(8'h55, 1'b1);
      tx(8'h01, 1'b1);
      `CHK("busy", 1'b0, nvm_busy)
      adr(1'b0);
      tx(icnvm_pkg::OFS_PROG_COUNT, 1'b1);
      adr(1'b1);
      rx(icnvm_pkg::RESET_BYTE, 1'b1);
      i_host.stop();
      adr(1'b0);
      tx(icnvm_pkg::OFS_UNLOCK, 1'b1);
      tx(icnvm_pkg::UNLOCK_CODE, 1'b1);
      tx(8'h02, 1'b1);
      adr(1'b0);
      tx(icnvm_pkg::OFS_NVM_CTRL, 1'b1);
      tx(8'h40, 1'b1);
      i_host.stop();
      // Page 2 now holds register 0x00 at shadow 0x100
      adr(1'b0);
      tx(icnvm_pkg::OFS_PTR_HIGH, 1'b1);
      tx(8'h01, 1'b1);
      tx(8'h00, 1'b1);
      adr(1'b0);
      tx(icnvm_pkg::OFS_MEM_DATA, 1'b1);
      adr(1'b1);
      rx(8'hC3, 1'b1);
      adr(1'b0);
      tx(icnvm_pkg::OFS_MEM_DATA, 1'b1);
      tx(8'h5A, 1'b1);
      i_host.stop();
      adr(1'b0);
      tx(icnvm_pkg::OFS_PTR_HIGH, 1'b1);
      tx(8'h01, 1'b1);
      tx(8'h01, 1'b1);
      adr(1'b0);
      tx(icnvm_pkg::OFS_MEM_DATA, 1'b1);
      adr(1'b1);
      rx(8'h5A, 1'b1);
      i_host.stop();
      adr(1'b0);
      tx(icnvm_pkg::OFS_NVM_CTRL, 1'b1);
      tx(8'h01, 1'b1);
      `CHK("busy", 1'b1, nvm_busy)
      i_host.stop();
      for (int i = 0; i < 1000 && nvm_busy === 1'b1; i++) begin
         @(posedge clk);
      end
      `CHK("busy end", 1'b0, nvm_busy)
      adr(1'b0);
      tx(icnvm_pkg::OFS_UNLOCK, 1'b1);
      tx(icnvm_pkg::RESET_BYTE, 1'b1);
      adr(1'b0);
      tx(icnvm_pkg::OFS_PROG_COUNT, 1'b1);
      adr(1'b1);
      rx(icnvm_pkg::RESET_BYTE + 8'h01, 1'b1);
      i_host.stop();
      complete_run();
   end
endmodule // tb
